// file: buffered_pipe_endpoints.sv
/*
 * Inbound and outbound buffered pipe endpoints with a small register block.
 * Holds the dual-clock FIFO, a level synchroniser and the top module.
 * Assumes the host pipe strobes and register strobes are synchronous to mclk_i
 * and that user strobes are synchronous to user_side_clock_i.
 */
// Chosen here: the register offsets and the address-and-strobe port.

module level_sync
    import buffered_pipe_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic d_i,
    output logic q_o
);
    logic [SYNC_STAGES-1:0] stage_reg;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            stage_reg <= '0;
        else
            stage_reg <= {stage_reg[SYNC_STAGES-2:0], d_i};
    end

    // Only accept a new value once the last two stages agree
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            q_o <= 1'b0;
        else if (stage_reg[1] == stage_reg[2])
            q_o <= stage_reg[2];
    end
endmodule // level_sync

module dual_clock_fifo
    import buffered_pipe_pkg::*;
(
    // Write side
    input wire logic wclk_i,
    input wire logic wrst_n_i,
    input wire logic wclr_i,
    input wire logic wen_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic wfull_o,
    output logic wempty_o,
    output logic [LEVEL_W-1:0] wlevel_o,
    output logic wovf_o,
    // Read side
    input wire logic rclk_i,
    input wire logic rrst_n_i,
    input wire logic rclr_i,
    input wire logic ren_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic rfull_o,
    output logic rempty_o,
    output logic [LEVEL_W-1:0] rlevel_o,
    output logic runf_o
);
    import buffered_pipe_pkg::*;

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [PTR_W-1:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
    logic [PTR_W-1:0] rgray_s1_reg, rgray_s2_reg, rgray_s3_reg;
    logic [PTR_W-1:0] wgray_s1_reg, wgray_s2_reg, wgray_s3_reg;
    logic [PTR_W-1:0] rbin_w, wbin_r, wbin_next, rbin_next, wcount, rcount;
    logic wdo, rdo;

    // Write domain
    assign rbin_w = gray2bin(rgray_s3_reg);
    assign wdo = wen_i && !wfull_o && !wclr_i;
    assign wbin_next = wbin_reg + {{(PTR_W-1){1'b0}}, wdo};
    assign wcount = wbin_next - rbin_w;

    always_ff @(posedge wclk_i or negedge wrst_n_i)
    begin
        if (!wrst_n_i)
        begin
            rgray_s1_reg <= PTR_RST;
            rgray_s2_reg <= PTR_RST;
            rgray_s3_reg <= PTR_RST;
        end
        else
        begin
            // Gray pointer changes one bit per step except when a clear resets it, so outside a clear the sampled word is never torn
            rgray_s1_reg <= rgray_reg;
            rgray_s2_reg <= rgray_s1_reg;
            rgray_s3_reg <= rgray_s2_reg;
        end
    end

    always_ff @(posedge wclk_i)
    begin
        if (wdo)
            mem[wbin_reg[ADDR_W-1:0]] <= wdata_i;
    end

    always_ff @(posedge wclk_i or negedge wrst_n_i)
    begin
        if (!wrst_n_i)
        begin
            wbin_reg <= PTR_RST;
            wgray_reg <= PTR_RST;
        end
        else
        begin
            wbin_reg <= wclr_i ? PTR_RST : wbin_next;
            wgray_reg <= wclr_i ? PTR_RST : bin2gray(wbin_next);
        end
    end

    // Flags lean safe: a stale read pointer can only make the FIFO look fuller
    always_ff @(posedge wclk_i or negedge wrst_n_i)
    begin
        if (!wrst_n_i)
        begin
            wfull_o <= 1'b0;
            wempty_o <= 1'b1;
            wlevel_o <= '0;
            wovf_o <= 1'b0;
        end
        else
        begin
            wfull_o <= !wclr_i && (wcount >= FIFO_DEPTH);
            wempty_o <= wclr_i || (wcount == PTR_RST);
            wlevel_o <= wclr_i ? '0 : wcount[ADDR_W-1:LEVEL_LSB];
            wovf_o <= !wclr_i && wen_i && wfull_o;
        end
    end

    // Read domain
    assign wbin_r = gray2bin(wgray_s3_reg);
    assign rdo = ren_i && !rempty_o && !rclr_i;
    assign rbin_next = rbin_reg + {{(PTR_W-1){1'b0}}, rdo};
    assign rcount = wbin_r - rbin_next;

    always_ff @(posedge rclk_i or negedge rrst_n_i)
    begin
        if (!rrst_n_i)
        begin
            wgray_s1_reg <= PTR_RST;
            wgray_s2_reg <= PTR_RST;
            wgray_s3_reg <= PTR_RST;
        end
        else
        begin
            wgray_s1_reg <= wgray_reg;
            wgray_s2_reg <= wgray_s1_reg;
            wgray_s3_reg <= wgray_s2_reg;
        end
    end

    always_ff @(posedge rclk_i or negedge rrst_n_i)
    begin
        if (!rrst_n_i)
            rdata_o <= '0;
        else if (rdo)
            rdata_o <= mem[rbin_reg[ADDR_W-1:0]];
    end

    always_ff @(posedge rclk_i or negedge rrst_n_i)
    begin
        if (!rrst_n_i)
        begin
            rbin_reg <= PTR_RST;
            rgray_reg <= PTR_RST;
        end
        else
        begin
            rbin_reg <= rclr_i ? PTR_RST : rbin_next;
            rgray_reg <= rclr_i ? PTR_RST : bin2gray(rbin_next);
        end
    end

    always_ff @(posedge rclk_i or negedge rrst_n_i)
    begin
        if (!rrst_n_i)
        begin
            rfull_o <= 1'b0;
            rempty_o <= 1'b1;
            rlevel_o <= '0;
            runf_o <= 1'b0;
        end
        else
        begin
            rfull_o <= !rclr_i && (rcount >= FIFO_DEPTH);
            rempty_o <= rclr_i || (rcount == PTR_RST);
            rlevel_o <= rclr_i ? '0 : rcount[ADDR_W-1:LEVEL_LSB];
            runf_o <= !rclr_i && ren_i && rempty_o;
        end
    end
endmodule // dual_clock_fifo

module buffered_pipe_endpoints
    import buffered_pipe_pkg::*;
(
    // Host-side clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [buffered_pipe_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [buffered_pipe_pkg::REG_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [buffered_pipe_pkg::REG_DW-1:0] reg_rdata_o,
    output logic irq_o,
    // Host pipe port
    input wire logic [buffered_pipe_pkg::SEL_W-1:0] host_endpoint_selector_i,
    input wire logic host_write_i,
    input wire logic [buffered_pipe_pkg::DATA_W-1:0] host_wdata_i,
    input wire logic host_read_i,
    output logic [buffered_pipe_pkg::DATA_W-1:0] host_rdata_o,
    // User side common
    input wire logic user_side_clock_i,
    input wire logic fifo_clear_i,
    // Inbound user port
    input wire logic pop_strobe_i,
    output logic [buffered_pipe_pkg::DATA_W-1:0] popped_word_o,
    output logic in_fifo_at_capacity_o,
    output logic in_fifo_drained_o,
    output logic [buffered_pipe_pkg::LEVEL_W-1:0] in_fill_level_code_o,
    // Outbound user port
    input wire logic push_strobe_i,
    input wire logic [buffered_pipe_pkg::DATA_W-1:0] pushed_word_i,
    output logic out_fifo_at_capacity_o,
    output logic out_fifo_drained_o,
    output logic [buffered_pipe_pkg::LEVEL_W-1:0] out_fill_level_code_o
);
    import buffered_pipe_pkg::*;

    logic [SEL_W-1:0] in_sel_reg, out_sel_reg;
    logic [EV_W-1:0] event_reg, mask_reg, event_set;
    logic host_clear;
    logic in_push, out_pull;
    logic in_host_full, in_host_empty, out_host_full, out_host_empty;
    logic [LEVEL_W-1:0] in_host_level, out_host_level;
    logic in_ovf, out_unf, in_unf_user, out_ovf_user;
    logic in_unf_tgl_reg, out_ovf_tgl_reg;
    logic in_unf_seen, out_ovf_seen, in_unf_seen_d_reg, out_ovf_seen_d_reg;

    // Host transfers count only when they name this endpoint
    assign in_push = host_write_i && (host_endpoint_selector_i == in_sel_reg);
    assign out_pull = host_read_i && (host_endpoint_selector_i == out_sel_reg);

    // The clear is a user-clock level; the host side follows it a few cycles late
    level_sync u_clear_sync (
        .clk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(fifo_clear_i),
        .q_o(host_clear)
    );

    dual_clock_fifo u_inbound (
        .wclk_i(mclk_i),
        .wrst_n_i(nrst_i),
        .wclr_i(host_clear),
        .wen_i(in_push),
        .wdata_i(host_wdata_i),
        .wfull_o(in_host_full),
        .wempty_o(in_host_empty),
        .wlevel_o(in_host_level),
        .wovf_o(in_ovf),
        .rclk_i(user_side_clock_i),
        .rrst_n_i(nrst_i),
        .rclr_i(fifo_clear_i),
        .ren_i(pop_strobe_i),
        .rdata_o(popped_word_o),
        .rfull_o(in_fifo_at_capacity_o),
        .rempty_o(in_fifo_drained_o),
        .rlevel_o(in_fill_level_code_o),
        .runf_o(in_unf_user)
    );

    dual_clock_fifo u_outbound (
        .wclk_i(user_side_clock_i),
        .wrst_n_i(nrst_i),
        .wclr_i(fifo_clear_i),
        .wen_i(push_strobe_i),
        .wdata_i(pushed_word_i),
        .wfull_o(out_fifo_at_capacity_o),
        .wempty_o(out_fifo_drained_o),
        .wlevel_o(out_fill_level_code_o),
        .wovf_o(out_ovf_user),
        .rclk_i(mclk_i),
        .rrst_n_i(nrst_i),
        .rclr_i(host_clear),
        .ren_i(out_pull),
        .rdata_o(host_rdata_o),
        .rfull_o(out_host_full),
        .rempty_o(out_host_empty),
        .rlevel_o(out_host_level),
        .runf_o(out_unf)
    );

    // User misuse is flagged to the host as a toggle crossing
    always_ff @(posedge user_side_clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            in_unf_tgl_reg <= 1'b0;
            out_ovf_tgl_reg <= 1'b0;
        end
        else
        begin
            in_unf_tgl_reg <= in_unf_tgl_reg ^ in_unf_user;
            out_ovf_tgl_reg <= out_ovf_tgl_reg ^ out_ovf_user;
        end
    end

    level_sync u_in_unf_sync (
        .clk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(in_unf_tgl_reg),
        .q_o(in_unf_seen)
    );

    level_sync u_out_ovf_sync (
        .clk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(out_ovf_tgl_reg),
        .q_o(out_ovf_seen)
    );

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            in_unf_seen_d_reg <= 1'b0;
            out_ovf_seen_d_reg <= 1'b0;
        end
        else
        begin
            in_unf_seen_d_reg <= in_unf_seen;
            out_ovf_seen_d_reg <= out_ovf_seen;
        end
    end

    always_comb
    begin
        event_set = '0;
        event_set[EV_IN_OVERRUN] = in_ovf;
        event_set[EV_OUT_UNDERRUN] = out_unf;
        event_set[EV_IN_UNDERRUN] = in_unf_seen ^ in_unf_seen_d_reg;
        event_set[EV_OUT_OVERRUN] = out_ovf_seen ^ out_ovf_seen_d_reg;
    end

    // Selectors and mask
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            in_sel_reg <= IN_SEL_RST;
            out_sel_reg <= OUT_SEL_RST;
            mask_reg <= MASK_RST;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == REG_IN_SEL)
                in_sel_reg <= reg_wdata_i[SEL_W-1:0];
            if (reg_addr_i == REG_OUT_SEL)
                out_sel_reg <= reg_wdata_i[SEL_W-1:0];
            if (reg_addr_i == REG_MASK)
                mask_reg <= reg_wdata_i[EV_W-1:0];
        end
    end

    // Sticky events, cleared by reading; a new event in the read cycle survives
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            event_reg <= '0;
        else if (reg_rd_i && reg_addr_i == REG_EVENT)
            event_reg <= event_set;
        else
            event_reg <= event_reg | event_set;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            irq_o <= 1'b0;
        else
            // Track the next event value, so a set during the clearing read keeps irq up
            irq_o <= |(((event_reg & ~{EV_W{reg_rd_i && reg_addr_i == REG_EVENT}}) | event_set)
                       & mask_reg);
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            reg_rdata_o <= '0;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                REG_IN_SEL: reg_rdata_o <= {{(REG_DW-SEL_W){1'b0}}, in_sel_reg};
                REG_OUT_SEL: reg_rdata_o <= {{(REG_DW-SEL_W){1'b0}}, out_sel_reg};
                REG_EVENT: reg_rdata_o <= {{(REG_DW-EV_W){1'b0}}, event_reg};
                REG_MASK: reg_rdata_o <= {{(REG_DW-EV_W){1'b0}}, mask_reg};
                REG_HOST_STAT: reg_rdata_o <= {16'h0000,
                                               out_host_level, out_host_full, out_host_empty,
                                               2'b00,
                                               in_host_level, in_host_full, in_host_empty,
                                               2'b00};
                default: reg_rdata_o <= '0;
            endcase
        end
        else
            reg_rdata_o <= '0;
    end
endmodule // buffered_pipe_endpoints

// file: buffered_pipe_pkg.sv
/*
 * Constants, register map and pointer helpers for the buffered pipe endpoints.
 * Assumes one host-facing clock (mclk_i) and one free-running user endpoint clock.
 */
package buffered_pipe_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 11;
    localparam int PTR_W = ADDR_W + 1;
    localparam int LEVEL_W = 4;
    localparam int SEL_W = 8;
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam int SYNC_STAGES = 3;

    // Usable entries: one slot of the 2048-word RAM stays unused
    localparam logic [PTR_W-1:0] FIFO_DEPTH = 12'h07FF;
    localparam int LEVEL_LSB = ADDR_W - LEVEL_W;

    // Register offsets (byte addresses)
    localparam logic [REG_AW-1:0] REG_IN_SEL = 8'h00;
    localparam logic [REG_AW-1:0] REG_OUT_SEL = 8'h04;
    localparam logic [REG_AW-1:0] REG_EVENT = 8'h08;
    localparam logic [REG_AW-1:0] REG_MASK = 8'h0C;
    localparam logic [REG_AW-1:0] REG_HOST_STAT = 8'h10;

    // Event bit positions
    localparam int EV_IN_OVERRUN = 0;
    localparam int EV_OUT_UNDERRUN = 1;
    localparam int EV_IN_UNDERRUN = 2;
    localparam int EV_OUT_OVERRUN = 3;
    localparam int EV_W = 4;

    // Reset values
    localparam logic [SEL_W-1:0] IN_SEL_RST = 8'h80;
    localparam logic [SEL_W-1:0] OUT_SEL_RST = 8'hA0;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;
    localparam logic [PTR_W-1:0] PTR_RST = 12'h000;

    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = g;
        for (int i = PTR_W - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// file: buffered_pipe_endpoints_assertions.sv
/* Concurrent checks on the buffered pipe endpoint ports.
   Assumes binding to buffered_pipe_endpoints; sees only its ports. */
module buffered_pipe_endpoints_assertions
    import buffered_pipe_pkg::*;
(
    // Clocks and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic user_side_clock_i,
    // Host side
    input wire logic reg_rd_i,
    input wire logic [buffered_pipe_pkg::REG_DW-1:0] reg_rdata_o,
    input wire logic host_read_i,
    input wire logic [buffered_pipe_pkg::DATA_W-1:0] host_rdata_o,
    // User side
    input wire logic fifo_clear_i,
    input wire logic pop_strobe_i,
    input wire logic [buffered_pipe_pkg::DATA_W-1:0] popped_word_o,
    input wire logic in_fifo_at_capacity_o,
    input wire logic in_fifo_drained_o,
    input wire logic [buffered_pipe_pkg::LEVEL_W-1:0] in_fill_level_code_o,
    input wire logic push_strobe_i,
    input wire logic out_fifo_at_capacity_o,
    input wire logic out_fifo_drained_o,
    input wire logic [buffered_pipe_pkg::LEVEL_W-1:0] out_fill_level_code_o
);
    timeunit 1ns;
    timeprecision 1ps;
    AST_RDATA_IDLE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !reg_rd_i |=> reg_rdata_o == '0) else $error("read data not zero outside a read");
    // A clear may reach the host side late, so it suspends this check
    AST_HOST_RD_HOLD: assert property (@(posedge mclk_i) disable iff (!nrst_i || fifo_clear_i)
        !host_read_i |=> $stable(host_rdata_o)) else $error("host data moved without a read");
    AST_POP_HOLD: assert property (@(posedge user_side_clock_i) disable iff (!nrst_i)
        !pop_strobe_i && !fifo_clear_i |=> $stable(popped_word_o)) else $error("popped word moved");
    AST_PUSH_FILLS: assert property (@(posedge user_side_clock_i) disable iff (!nrst_i)
        push_strobe_i && !out_fifo_at_capacity_o && !fifo_clear_i |=> !out_fifo_drained_o)
        else $error("push left outbound empty");
    AST_CLEAR_DRAINS: assert property (@(posedge user_side_clock_i) disable iff (!nrst_i)
        fifo_clear_i [*8] |-> in_fifo_drained_o && out_fifo_drained_o
        && in_fill_level_code_o == 4'h0 && out_fill_level_code_o == 4'h0)
        else $error("clear did not empty the endpoints");
    AST_IN_FULL_LEVEL: assert property (@(posedge user_side_clock_i) disable iff (!nrst_i)
        in_fifo_at_capacity_o |-> in_fill_level_code_o == 4'hF) else $error("full but level not top");
    AST_IN_EMPTY_LEVEL: assert property (@(posedge user_side_clock_i) disable iff (!nrst_i)
        in_fifo_drained_o |-> in_fill_level_code_o == 4'h0) else $error("empty but level not zero");
    AST_IN_EXCL: assert property (@(posedge user_side_clock_i) disable iff (!nrst_i)
        !(in_fifo_at_capacity_o && in_fifo_drained_o)) else $error("inbound full and empty");
    AST_OUT_EXCL: assert property (@(posedge user_side_clock_i) disable iff (!nrst_i)
        !(out_fifo_at_capacity_o && out_fifo_drained_o)) else $error("outbound full and empty");
endmodule // buffered_pipe_endpoints_assertions

bind buffered_pipe_endpoints buffered_pipe_endpoints_assertions u_checker (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .user_side_clock_i(user_side_clock_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .host_read_i(host_read_i),
    .host_rdata_o(host_rdata_o), .fifo_clear_i(fifo_clear_i), .pop_strobe_i(pop_strobe_i),
    .popped_word_o(popped_word_o), .in_fifo_at_capacity_o(in_fifo_at_capacity_o),
    .in_fifo_drained_o(in_fifo_drained_o), .in_fill_level_code_o(in_fill_level_code_o),
    .push_strobe_i(push_strobe_i), .out_fifo_at_capacity_o(out_fifo_at_capacity_o),
    .out_fifo_drained_o(out_fifo_drained_o), .out_fill_level_code_o(out_fill_level_code_o)
);

// file: host_pipe_model.sv
/* Host interface controller model: pushes and pulls pipe words on the host clock.
   Assumes tasks are entered just after a rising edge of mclk_i. */
module host_pipe_model
    import buffered_pipe_pkg::*;
(
    // Host clock
    input wire logic mclk_i,
    // Host pipe port
    output logic [buffered_pipe_pkg::SEL_W-1:0] selector_o,
    output logic write_o,
    output logic [buffered_pipe_pkg::DATA_W-1:0] wdata_o,
    output logic read_o,
    input wire logic [buffered_pipe_pkg::DATA_W-1:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] got[$];
    initial
    begin
        selector_o = 8'h00;
        write_o = 1'b0;
        wdata_o = 16'hFFFF;
        read_o = 1'b0;
    end
    // Host is master: words leave whenever it chooses, one per edge
    task automatic push_burst(input logic [SEL_W-1:0] sel, input logic [DATA_W-1:0] base,
                              input int n);
        // Realign to mclk_i: the caller may come from the user clock
        @(posedge mclk_i);
        #1;
        for (int i = 0; i < n; i++)
        begin
            selector_o <= sel;
            wdata_o <= base + DATA_W'(i);
            write_o <= 1'b1;
            @(posedge mclk_i);
        end
        // Released lines must not keep showing the last word
        write_o <= 1'b0;
        wdata_o <= ~wdata_o;
        selector_o <= ~sel;
        #1;
    endtask
    task automatic pull_burst(input logic [SEL_W-1:0] sel, input int n);
        selector_o <= sel;
        read_o <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk_i);
            if (i == n - 1)
            begin
                read_o <= 1'b0;
                selector_o <= ~sel;
            end
            #1;
            got.push_back(rdata_i);
        end
    endtask
endmodule // host_pipe_model

// file: test_buffered_pipe_endpoints.sv
/* Self-checking bench for the buffered pipe endpoints.
   Assumes the host pipe port is driven by host_pipe_model and a 31 ns user clock. */
module test_buffered_pipe_endpoints;
    import buffered_pipe_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, uclk = 1'b0, nrst = 1'b0;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [REG_DW-1:0] reg_wdata = '0, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, irq, h_wr, h_rd, clr = 1'b0, pop = 1'b0, push = 1'b0;
    logic [SEL_W-1:0] h_sel;
    logic [DATA_W-1:0] h_wdata, h_rdata, popped, pushed = 16'hFFFF;
    logic in_full, in_empty, out_full, out_empty;
    logic [LEVEL_W-1:0] in_level, out_level;
    int bad_count = 0, check_count = 0;
    always #12.5 mclk = ~mclk;
    always #15.5 uclk = ~uclk;
    buffered_pipe_endpoints u_buffered_pipe_endpoints (.mclk_i(mclk), .nrst_i(nrst),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .irq_o(irq), .host_endpoint_selector_i(h_sel),
        .host_write_i(h_wr), .host_wdata_i(h_wdata), .host_read_i(h_rd),
        .host_rdata_o(h_rdata), .user_side_clock_i(uclk), .fifo_clear_i(clr),
        .pop_strobe_i(pop), .popped_word_o(popped), .in_fifo_at_capacity_o(in_full),
        .in_fifo_drained_o(in_empty), .in_fill_level_code_o(in_level), .push_strobe_i(push),
        .pushed_word_i(pushed), .out_fifo_at_capacity_o(out_full),
        .out_fifo_drained_o(out_empty), .out_fill_level_code_o(out_level));
    host_pipe_model host_side (.mclk_i(mclk), .selector_o(h_sel), .write_o(h_wr),
        .wdata_o(h_wdata), .read_o(h_rd), .rdata_i(h_rdata));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_write(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
        // Realign to mclk: callers may come straight from the user clock
        @(posedge mclk);
        #1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic reg_check(input string what, input logic [REG_AW-1:0] a,
                             input logic [REG_DW-1:0] exp);
        @(posedge mclk);
        #1;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
    endtask
    task automatic user_wait(input int n);
        repeat (n) @(posedge uclk);
        #1;
    endtask
    task automatic pop_check(input logic [DATA_W-1:0] base, input int n);
        user_wait(1);
        pop <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge uclk);
            if (i == n - 1)
                pop <= 1'b0;
            #1;
            check("popped word", base + i, popped);
        end
    endtask
    task automatic push_words(input logic [DATA_W-1:0] base, input int n);
        user_wait(1);
        for (int i = 0; i < n; i++)
        begin
            pushed <= base + DATA_W'(i);
            push <= 1'b1;
            @(posedge uclk);
        end
        push <= 1'b0;
        pushed <= ~pushed;
        #1;
    endtask
    task automatic t_regs();
        reg_check("inbound selector", REG_IN_SEL, {24'h00_0000, IN_SEL_RST});
        reg_check("outbound selector", REG_OUT_SEL, {24'h00_0000, OUT_SEL_RST});
        reg_check("mask", REG_MASK, 32'h0000_0000);
        reg_check("unmapped", 8'h40, 32'h0000_0000);
        reg_write(REG_IN_SEL, 32'h0000_0087);
        reg_check("inbound selector", REG_IN_SEL, 32'h0000_0087);
    endtask
    task automatic t_inbound();
        host_side.push_burst(8'h86, 16'h1111, 2);
        host_side.push_burst(8'h87, 16'h2000, 4);
        user_wait(12);
        check("inbound empty", 1'b0, in_empty);
        pop_check(16'h2000, 4);
        user_wait(2);
        check("inbound empty", 1'b1, in_empty);
    endtask
    task automatic t_outbound();
        push_words(16'h3000, 5);
        check("outbound empty", 1'b0, out_empty);
        check("outbound level", 4'h0, out_level);
        repeat (12) @(posedge mclk);
        #1;
        host_side.pull_burst(OUT_SEL_RST, 5);
        for (int i = 0; i < 5; i++)
            check("host word", 16'h3000 + i, host_side.got[i]);
        user_wait(12);
        check("outbound empty", 1'b1, out_empty);
    endtask
    task automatic t_fill();
        reg_write(REG_MASK, 32'h0000_0001);
        host_side.push_burst(8'h87, 16'h0000, 128);
        user_wait(12);
        check("level at 128", 4'h1, in_level);
        check("irq idle", 1'b0, irq);
        host_side.push_burst(8'h87, 16'h0080, 1920);
        user_wait(12);
        check("inbound full", 1'b1, in_full);
        check("level at top", 4'hF, in_level);
        check("irq raised", 1'b1, irq);
        reg_check("host status", REG_HOST_STAT, 32'h0000_04F8);
        reg_check("events", REG_EVENT, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        #1;
        check("irq cleared", 1'b0, irq);
        pop_check(16'h0000, 1);
        user_wait(2);
        check("inbound full", 1'b0, in_full);
    endtask
    task automatic t_clear_underrun();
        push_words(16'h4000, 2048);
        check("outbound full", 1'b1, out_full);
        check("outbound level", 4'hF, out_level);
        user_wait(12);
        reg_check("events", REG_EVENT, 32'h0000_0008);
        user_wait(1);
        clr <= 1'b1;
        user_wait(10);
        clr <= 1'b0;
        user_wait(2);
        check("inbound empty", 1'b1, in_empty);
        check("inbound level", 4'h0, in_level);
        check("outbound empty", 1'b1, out_empty);
        pop <= 1'b1;
        user_wait(1);
        pop <= 1'b0;
        user_wait(12);
        check("popped word held", 16'h0000, popped);
        reg_check("events", REG_EVENT, 32'h0000_0004);
        check("irq masked", 1'b0, irq);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        close_out();
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1;
        t_regs();
        t_inbound();
        t_outbound();
        t_fill();
        t_clear_underrun();
        close_out();
    end
endmodule // test_buffered_pipe_endpoints
